//--- design/tpc_top.sv
// Counter snapshot group and per-channel signaling store of one T1 link
// Assumes framer strobes and format come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
// How it works
// [RULE_01] Change flags 17-24 at bits 0-7, write-one-clear
// [RULE_02] Trigger bit rising copies all counters together
// [RULE_03] Auto bit refreshes snapshot every second
// [RULE_04] Ten-bit CRC-6 count at 00h and 01h
// [RULE_05] Twelve-bit framing error count at 02h, 03h
// [RULE_06] Three-bit frame position change count at 04h
// [RULE_07] Five-bit loss of frame count at 05h
// [RULE_08] Sixteen-bit pattern error count at 06h, 07h
// [RULE_09] Sixteen-bit line violation count at 08h, 09h
// [RULE_10] Ten-bit DDS pattern error count at 0ah, 0bh
// [RULE_11] One signaling register per channel, 01h-18h
// [RULE_12] Synced and enabled channels load received signaling
// [RULE_13] Software disables extraction in DM format
// [RULE_14] SF stores third, fourth bits as first, second
// [RULE_15] Data before address on write, after on read
// [RULE_16] No new indirect access while busy
// [RULE_17] Four-state mode keeps only first two bits
// [RULE_18] Counters restart on copy and saturate
module tpc_top #(
  parameter int unsigned SECOND_CYCLES = tpc_pkg::SECOND_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [7:0]       busAddr,
  input  wire logic             busWr,
  input  wire logic             busRd,
  input  wire logic [7:0]       busWdata,
  output logic      [7:0]       busRdata,
  output logic                  accessBusy,
  input  wire tpc_pkg::tpc_fmt_t lineFormat,
  input  wire logic             frameSynced,
  input  wire logic             crcErrEvt,
  input  wire logic             fbitErrEvt,
  input  wire logic             posChangeEvt,
  input  wire logic             lossFrameEvt,
  input  wire logic             patErrEvt,
  input  wire logic             lineViolEvt,
  input  wire logic             ddsErrEvt,
  input  wire logic             sigStrobe,
  input  wire logic [4:0]       sigChannel,
  input  wire logic [3:0]       sigBits
);
  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic chanOk(input logic [6:0] a);
    chanOk = (a >= tpc_pkg::CH_FIRST) && (a <= tpc_pkg::CH_LAST);
  endfunction

  function automatic logic [7:0] pmonByte(input logic [7:0] a,
                                          input logic [71:0] s);
    pmonByte = 8'h00;
    case (a)
      tpc_pkg::PM_CRC_LO: pmonByte = s[7:0]; // see [RULE_04]
      tpc_pkg::PM_CRC_HI: pmonByte = {2'h0, s[9:8], 4'h0}; // see [RULE_04]
      tpc_pkg::PM_FER_LO: pmonByte = s[17:10]; // see [RULE_05]
      tpc_pkg::PM_FER_HI: pmonByte = {4'h0, s[21:18]}; // see [RULE_05]
      tpc_pkg::PM_POS:    pmonByte = {5'h00, s[24:22]}; // see [RULE_06]
      tpc_pkg::PM_LOF:    pmonByte = {3'h0, s[29:25]}; // see [RULE_07]
      tpc_pkg::PM_PAT_LO: pmonByte = s[37:30]; // see [RULE_08]
      tpc_pkg::PM_PAT_HI: pmonByte = s[45:38]; // see [RULE_08]
      tpc_pkg::PM_LCV_LO: pmonByte = s[53:46]; // see [RULE_09]
      tpc_pkg::PM_LCV_HI: pmonByte = s[61:54]; // see [RULE_09]
      tpc_pkg::PM_DDS_LO: pmonByte = s[69:62]; // see [RULE_10]
      tpc_pkg::PM_DDS_HI: pmonByte = {6'h00, s[71:70]}; // see [RULE_10]
      default:            pmonByte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Counter bank and snapshot
  tpc_cnt_if cnt ();
  logic       tick;
  logic [1:0] pmonCtrl_q;
  logic [7:0] pmonSel_q;
  logic [71:0] snap_q;
  logic       wrCtrl;
  logic       snapTake;

  assign cnt.inc = {ddsErrEvt, lineViolEvt, patErrEvt, lossFrameEvt,
                    posChangeEvt, fbitErrEvt, crcErrEvt};
  assign wrCtrl = busWr && (busAddr == tpc_pkg::ADDR_PERF_MONITOR_CTRL);
  // Copy on a 0-to-1 of the trigger or, with the auto bit set, on the second tick
  assign snapTake = (wrCtrl && busWdata[tpc_pkg::TRIG_BIT] // see [RULE_02]
                     && !pmonCtrl_q[tpc_pkg::TRIG_BIT])
                    || (tick && pmonCtrl_q[tpc_pkg::AUTO_BIT]); // see [RULE_03]
  assign cnt.take = snapTake;

  tpc_counter_bank u_bank (
    .clk  (clk),
    .rstn (rstn),
    .cnt  (cnt)
  );

  tpc_second_tick #(
    .PERIOD (SECOND_CYCLES)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pmonCtrl_q <= tpc_pkg::PERF_MONITOR_CTRL_RST;
    end else if (wrCtrl) begin
      pmonCtrl_q <= busWdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pmonSel_q <= 8'h00;
    end else if (busWr && busAddr == tpc_pkg::ADDR_PERF_MONITOR_SEL) begin
      pmonSel_q <= busWdata;
    end
  end

  // Whole group copied in one edge so software sees one coherent period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snap_q <= '0;
    end else if (snapTake) begin
      snap_q <= cnt.count; // see [RULE_02] [RULE_03]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect access to the channel registers
  tpc_pkg::tpc_acc_t accState_q;
  logic [1:0] waitCnt_q;
  logic [7:0] accCtrl_q;
  logic [7:0] accData_q;
  logic       accept;
  logic       accDone;
  logic [4:0] accIdx;
  logic [23:0]      extEn_q;
  logic [23:0][3:0] sig_q;

  assign accept = busWr && (busAddr == tpc_pkg::ADDR_ACC_CTRL)
                  && (accState_q == tpc_pkg::ACC_IDLE); // see [RULE_16]
  assign accDone = (accState_q == tpc_pkg::ACC_WAIT) && (waitCnt_q == 2'h0);
  assign accIdx = 5'(accCtrl_q[6:0] - tpc_pkg::CH_FIRST);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accState_q <= tpc_pkg::ACC_IDLE;
      waitCnt_q  <= 2'h0;
    end else begin
      case (accState_q)
        tpc_pkg::ACC_IDLE: begin
          if (accept) begin
            accState_q <= tpc_pkg::ACC_WAIT;
            waitCnt_q  <= 2'(tpc_pkg::BUSY_CYCLES - 1);
          end
        end
        tpc_pkg::ACC_WAIT: begin
          if (waitCnt_q == 2'h0) begin
            accState_q <= tpc_pkg::ACC_IDLE;
          end else begin
            waitCnt_q <= 2'(waitCnt_q - 1'b1);
          end
        end
        default: begin
          accState_q <= tpc_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accessBusy <= 1'b0;
    end else if (accept) begin
      accessBusy <= 1'b1; // see [RULE_16]
    end else if (accDone) begin
      accessBusy <= 1'b0;
    end
  end

  // Control writes while busy are dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accCtrl_q <= 8'h00;
    end else if (accept) begin
      accCtrl_q <= busWdata;
    end
  end

  // Data written first for a write, filled in at the end of a read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accData_q <= 8'h00;
    end else if (accDone && accCtrl_q[tpc_pkg::RNW_BIT]) begin
      accData_q <= chanOk(accCtrl_q[6:0]) // see [RULE_11] [RULE_15]
                   ? {3'h0, extEn_q[accIdx], sig_q[accIdx]} : 8'h00;
    end else if (busWr && busAddr == tpc_pkg::ADDR_ACC_DATA
                 && accState_q == tpc_pkg::ACC_IDLE) begin
      accData_q <= busWdata; // see [RULE_15]
    end
  end

  // Only the extraction enable is writable; signaling bits are read-only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extEn_q <= {tpc_pkg::NUM_CH{tpc_pkg::EXTRACT_RST}};
    end else if (accDone && !accCtrl_q[tpc_pkg::RNW_BIT]
                 && chanOk(accCtrl_q[6:0])) begin
      extEn_q[accIdx] <= accData_q[tpc_pkg::EXTRACT_BIT]; // see [RULE_11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signaling extraction and change flags
  logic       sixteen_q;
  logic [4:0] sigIdx;
  logic       extLoad;
  logic [3:0] sigNew;
  logic [23:0] chg_q;
  logic [23:0] chgClr;

  assign sigIdx = 5'(sigChannel - 5'h01);
  // DM carries no signaling, so nothing loads there even if left enabled
  assign extLoad = sigStrobe && frameSynced // see [RULE_12] [RULE_13]
                   && (lineFormat != tpc_pkg::FMT_DM)
                   && chanOk({2'h0, sigChannel}) && extEn_q[sigIdx];

  always_comb begin
    sigNew = sigBits;
    if (lineFormat == tpc_pkg::FMT_SF) begin
      sigNew = {sigBits[3:2], sigBits[3:2]}; // see [RULE_14]
    end else if (!sixteen_q) begin
      sigNew = {sigBits[3:2], 2'h0}; // see [RULE_17]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sixteen_q <= tpc_pkg::SIXTEEN_RST;
    end else if (busWr && busAddr == tpc_pkg::ADDR_SIG_CFG) begin
      sixteen_q <= busWdata[tpc_pkg::SIXTEEN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sig_q <= '0;
    end else if (extLoad) begin
      sig_q[sigIdx] <= sigNew; // see [RULE_12]
    end
  end

  assign chgClr = {busWr && busAddr == tpc_pkg::ADDR_CHG2 ? busWdata : 8'h00,
                   busWr && busAddr == tpc_pkg::ADDR_CHG1 ? busWdata : 8'h00,
                   busWr && busAddr == tpc_pkg::ADDR_CHG0 ? busWdata : 8'h00};

  // A change in the clearing cycle keeps its flag set
  genvar c;
  generate
    for (c = 0; c < tpc_pkg::NUM_CH; c++) begin : g_chg
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          chg_q[c] <= 1'b0;
        end else if (extLoad && sigIdx == 5'(c) && sigNew != sig_q[c]) begin
          chg_q[c] <= 1'b1; // see [RULE_01]
        end else if (chgClr[c]) begin
          chg_q[c] <= 1'b0; // see [RULE_01]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data appears the edge after the read strobe
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    case (busAddr)
      tpc_pkg::ADDR_PERF_MONITOR_CTRL: rdMux = {6'h00, pmonCtrl_q};
      tpc_pkg::ADDR_PERF_MONITOR_SEL:  rdMux = pmonSel_q;
      tpc_pkg::ADDR_PERF_MONITOR_DATA: rdMux = pmonByte(pmonSel_q, snap_q);
      tpc_pkg::ADDR_SIG_CFG:   rdMux = {7'h00, sixteen_q};
      tpc_pkg::ADDR_BUSY:      rdMux = {7'h00, accessBusy};
      tpc_pkg::ADDR_ACC_CTRL:  rdMux = accCtrl_q;
      tpc_pkg::ADDR_ACC_DATA:  rdMux = accData_q;
      tpc_pkg::ADDR_CHG0:      rdMux = chg_q[7:0];
      tpc_pkg::ADDR_CHG1:      rdMux = chg_q[15:8];
      tpc_pkg::ADDR_CHG2:      rdMux = chg_q[23:16]; // see [RULE_01]
      default:                 rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busRdata <= 8'h00;
    end else if (busRd) begin
      busRdata <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_snap_trigger: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_02]
    wrCtrl && busWdata[1] && !pmonCtrl_q[1] |=> snap_q == $past(cnt.count))
    else $error("trigger edge did not copy the counters");
  a_snap_auto: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_03]
    tick && pmonCtrl_q[0] |=> snap_q == $past(cnt.count))
    else $error("second tick did not refresh the snapshot");
  a_snap_hold: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_02]
    !(wrCtrl && busWdata[1] && !pmonCtrl_q[1]) && !(tick && pmonCtrl_q[0])
    |=> $stable(snap_q))
    else $error("snapshot changed without a trigger");
  a_busy_window: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_16]
    accept |=> accessBusy [*2] ##1 !accessBusy)
    else $error("busy flag length is wrong");
  a_busy_refuse: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_16]
    accessBusy && busWr && busAddr == tpc_pkg::ADDR_ACC_CTRL
    |=> $stable(accCtrl_q))
    else $error("control accepted while busy");
  a_read_chan: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_11]
    accDone && accCtrl_q[7] && chanOk(accCtrl_q[6:0])
    |=> accData_q == {3'h0, $past(extEn_q[accIdx]), $past(sig_q[accIdx])})
    else $error("indirect read returned wrong channel data");
  a_no_extract: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_12]
    sigStrobe && (!frameSynced || lineFormat == tpc_pkg::FMT_DM
                  || !extEn_q[sigIdx]) |=> $stable(sig_q))
    else $error("signaling loaded while extraction is off");
  a_sf_repeat: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_14]
    extLoad && lineFormat == tpc_pkg::FMT_SF
    |=> sig_q[$past(sigIdx)] == {2{$past(sigBits[3:2])}})
    else $error("SF signaling not repeated");
  a_four_state: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_17]
    extLoad && lineFormat != tpc_pkg::FMT_SF && !sixteen_q
    |=> sig_q[$past(sigIdx)][1:0] == 2'h0)
    else $error("four-state mode kept the low bits");
  a_chg_set: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_01]
    extLoad && sigNew != sig_q[sigIdx] |=> chg_q[$past(sigIdx)])
    else $error("change flag not set");
endmodule
`default_nettype wire

//--- design/tpc_pkg.sv
// Constants, types and register map of the T1 counter and signaling block
// Assumes a byte-wide register port on the same clock as the framer logic
package tpc_pkg;
  // Direct register offsets
  localparam logic [7:0] ADDR_PERF_MONITOR_CTRL = 8'hc2;
  localparam logic [7:0] ADDR_PERF_MONITOR_SEL  = 8'hc3;
  localparam logic [7:0] ADDR_PERF_MONITOR_DATA = 8'hc4;
  localparam logic [7:0] ADDR_SIG_CFG   = 8'hd2;
  localparam logic [7:0] ADDR_BUSY      = 8'hd3;
  localparam logic [7:0] ADDR_ACC_CTRL  = 8'hd4;
  localparam logic [7:0] ADDR_ACC_DATA  = 8'hd5;
  localparam logic [7:0] ADDR_CHG0      = 8'hd6;
  localparam logic [7:0] ADDR_CHG1      = 8'hd7;
  localparam logic [7:0] ADDR_CHG2      = 8'hd8;
  // Field positions
  localparam int AUTO_BIT    = 0;
  localparam int TRIG_BIT    = 1;
  localparam int SIXTEEN_BIT = 0;
  localparam int RNW_BIT     = 7;
  localparam int EXTRACT_BIT = 4;
  // Reset values
  localparam logic [1:0] PERF_MONITOR_CTRL_RST = 2'h0;
  localparam logic       SIXTEEN_RST   = 1'b1;
  localparam logic       EXTRACT_RST   = 1'b1;
  // Indirect offsets of the counter snapshot group
  localparam logic [7:0] PM_CRC_LO  = 8'h00;
  localparam logic [7:0] PM_CRC_HI  = 8'h01;
  localparam logic [7:0] PM_FER_LO  = 8'h02;
  localparam logic [7:0] PM_FER_HI  = 8'h03;
  localparam logic [7:0] PM_POS     = 8'h04;
  localparam logic [7:0] PM_LOF     = 8'h05;
  localparam logic [7:0] PM_PAT_LO  = 8'h06;
  localparam logic [7:0] PM_PAT_HI  = 8'h07;
  localparam logic [7:0] PM_LCV_LO  = 8'h08;
  localparam logic [7:0] PM_LCV_HI  = 8'h09;
  localparam logic [7:0] PM_DDS_LO  = 8'h0a;
  localparam logic [7:0] PM_DDS_HI  = 8'h0b;
  // Signaling channels at indirect 01h..18h
  localparam logic [6:0] CH_FIRST = 7'h01;
  localparam logic [6:0] CH_LAST  = 7'h18;
  localparam int         NUM_CH   = 24;
  // Counter bank layout: crc, fer, pos, lof, pattern, lcv, dds
  localparam int CNT_NUM   = 7;
  localparam int CNT_TOTAL = 72;
  localparam int CNT_W   [CNT_NUM] = '{10, 12, 3, 5, 16, 16, 10};
  localparam int CNT_OFS [CNT_NUM] = '{0, 10, 22, 25, 30, 46, 62};
  // Timing
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SECOND_S      = 1;
  localparam int unsigned SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int          TICK_W        = 25;
  localparam int unsigned BUSY_NS       = 100;
  localparam int unsigned CLK_NS        = 50;
  localparam int unsigned BUSY_CYCLES   = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {FMT_SF, FMT_ESF, FMT_DM, FMT_SLC} tpc_fmt_t;
  typedef enum logic {ACC_IDLE, ACC_WAIT} tpc_acc_t;
endpackage

//--- design/tpc_cnt_if.sv
// Event and snapshot signals between the top and its counter bank
// Assumes both ends on the one block clock
`timescale 1ns/100ps
`default_nettype none
interface tpc_cnt_if;
  logic [tpc_pkg::CNT_NUM-1:0]   inc;
  logic                          take;
  logic [tpc_pkg::CNT_TOTAL-1:0] count;
  modport bank (input inc, input take, output count);
  modport user (output inc, output take, input count);
endinterface
`default_nettype wire

//--- design/tpc_counter_bank.sv
// Saturating error counters that restart when copied to the snapshot
// Assumes one-cycle event pulses on the block clock
`timescale 1ns/100ps
`default_nettype none
module tpc_counter_bank (
  input  wire logic clk,
  input  wire logic rstn,
  tpc_cnt_if.bank   cnt
);
  genvar i;
  generate
    for (i = 0; i < tpc_pkg::CNT_NUM; i++) begin : g_cnt
      localparam int W = tpc_pkg::CNT_W[i];
      localparam int O = tpc_pkg::CNT_OFS[i];
      logic [W-1:0] c_q;
      // Event in the copy cycle opens the new period with a count of one
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          c_q <= '0;
        end else if (cnt.take) begin
          c_q <= W'(cnt.inc[i]); // see [RULE_18]
        end else if (cnt.inc[i] && !(&c_q)) begin
          c_q <= W'(c_q + 1'b1); // see [RULE_18]
        end
      end
      assign cnt.count[O +: W] = c_q;
      a_count_saturate: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_18]
        (&c_q) && !cnt.take |=> (&c_q))
        else $error("counter wrapped past its maximum");
      a_count_restart: assert property (@(posedge clk) disable iff (!rstn) // see [RULE_18]
        cnt.take && !cnt.inc[i] |=> c_q == '0)
        else $error("counter did not restart after copy");
    end
  endgenerate
endmodule
`default_nettype wire

//--- design/tpc_second_tick.sv
// One-cycle pulse once every PERIOD cycles of the block clock
// Assumes PERIOD fits in TICK_W bits
`timescale 1ns/100ps
`default_nettype none
module tpc_second_tick #(
  parameter int unsigned PERIOD = tpc_pkg::SECOND_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      tick
);
  localparam logic [tpc_pkg::TICK_W-1:0] LAST = tpc_pkg::TICK_W'(PERIOD - 1);
  logic [tpc_pkg::TICK_W-1:0] cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= tpc_pkg::TICK_W'(cnt_q + 1'b1);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
    end
  end
endmodule
`default_nettype wire

//--- dv/tpc_top_tb.sv
// Self-checking bench of the T1 counter snapshot and signaling block
// Assumes one 20 MHz clock; inputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module tpc_top_tb;
  localparam int unsigned SEC = 50;
  localparam int CW [7] = '{10, 12, 3, 5, 16, 16, 10};
  localparam logic [7:0] RA [7] = '{tpc_pkg::ADDR_PERF_MONITOR_CTRL, tpc_pkg::ADDR_SIG_CFG,
    tpc_pkg::ADDR_BUSY, tpc_pkg::ADDR_CHG0, tpc_pkg::ADDR_CHG1, tpc_pkg::ADDR_CHG2, 8'h40};
  localparam logic [7:0] RE [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic              clk;
  logic              rstn;
  logic [7:0]        busAddr;
  logic              busWr;
  logic              busRd;
  logic [7:0]        busWdata;
  logic [7:0]        busRdata;
  logic              accessBusy;
  tpc_pkg::tpc_fmt_t lineFormat;
  logic              frameSynced;
  logic [6:0]        ev;
  logic              crcRun;
  logic              sigStrobe;
  logic [4:0]        sigChannel;
  logic [3:0]        sigBits;
  int                n_errors;
  int                n_compared;
  logic [15:0]       cnt [7];
  logic [15:0]       snap [7];
  logic [3:0]        sig [25];
  logic              en [25];
  logic [7:0]        rv;
  logic [7:0]        fl;
  logic [7:0]        grp;
  logic              sixteen;
  logic              hit;
  int                ch;

  tpc_top #(.SECOND_CYCLES(SEC)) dut_u (
    .clk(clk), .rstn(rstn), .busAddr(busAddr), .busWr(busWr), .busRd(busRd),
    .busWdata(busWdata), .busRdata(busRdata), .accessBusy(accessBusy),
    .lineFormat(lineFormat), .frameSynced(frameSynced), .crcErrEvt(ev[0] | crcRun),
    .fbitErrEvt(ev[1]), .posChangeEvt(ev[2]), .lossFrameEvt(ev[3]), .patErrEvt(ev[4]),
    .lineViolEvt(ev[5]), .ddsErrEvt(ev[6]), .sigStrobe(sigStrobe),
    .sigChannel(sigChannel), .sigBits(sigBits)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    busAddr = a;
    busWdata = d;
    busWr = 1'b1;
    @(negedge clk);
    busWr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    busAddr = a;
    busRd = 1'b1;
    @(negedge clk);
    busRd = 1'b0;
    d = busRdata;
  endtask

  // Bounded wait so a stuck busy shows as a mismatch, not a hang
  task automatic idle();
    int k;
    chk({7'h0, accessBusy}, 8'h01);
    k = 0;
    while (accessBusy !== 1'b0 && k < 20) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic ird(input int c, output logic [7:0] d);
    wr(tpc_pkg::ADDR_ACC_CTRL, 8'h80 | 8'(c));
    idle();
    rd(tpc_pkg::ADDR_ACC_DATA, d);
  endtask

  task automatic iwr(input int c, input logic [7:0] d);
    wr(tpc_pkg::ADDR_ACC_DATA, d);
    wr(tpc_pkg::ADDR_ACC_CTRL, 8'(c));
    idle();
  endtask

  task automatic events(input int n);
    repeat (n) begin
      @(negedge clk);
      ev = 7'($urandom);
      for (int i = 0; i < 7; i++) begin
        if (ev[i] && cnt[i] < (1 << CW[i]) - 1) begin
          cnt[i]++;
        end
      end
    end
    @(negedge clk);
    ev = 7'h00;
  endtask

  function automatic logic [7:0] expByte(input int a);
    case (a)
      0: return snap[0][7:0];
      1: return {2'h0, snap[0][9:8], 4'h0};
      2: return snap[1][7:0];
      3: return {4'h0, snap[1][11:8]};
      4: return snap[2][7:0];
      5: return snap[3][7:0];
      6: return snap[4][7:0];
      7: return snap[4][15:8];
      8: return snap[5][7:0];
      9: return snap[5][15:8];
      10: return snap[6][7:0];
      default: return {6'h0, snap[6][9:8]};
    endcase
  endfunction

  task automatic chkSnap();
    for (int a = 0; a < 12; a++) begin
      wr(tpc_pkg::ADDR_PERF_MONITOR_SEL, 8'(a));
      rd(tpc_pkg::ADDR_PERF_MONITOR_DATA, rv);
      chk(rv, expByte(a));
    end
  endtask

  function automatic logic [3:0] shape(input tpc_pkg::tpc_fmt_t f, input logic s,
                                       input logic [3:0] x);
    if (f == tpc_pkg::FMT_SF) return {x[3:2], x[3:2]};
    if (!s) return {x[3:2], 2'h0};
    return x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_errors++;
    results();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    rstn = 1'b0;
    busAddr = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    busWdata = 8'h00;
    lineFormat = tpc_pkg::FMT_SF;
    frameSynced = 1'b0;
    ev = 7'h00;
    crcRun = 1'b0;
    sigStrobe = 1'b0;
    sigChannel = 5'h00;
    sigBits = 4'h0;
    rv = 8'($urandom(32'hcb9d));
    for (int i = 0; i < 7; i++) begin
      cnt[i] = 16'h0;
      snap[i] = 16'h0;
    end
    for (int i = 1; i < 25; i++) begin
      sig[i] = 4'h0;
      en[i] = 1'b1;
    end
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    foreach (RA[i]) begin
      rd(RA[i], rv);
      chk(rv, RE[i]);
    end
    chkSnap();
    for (int c = 0; c < 26; c++) begin
      ird(c, rv);
      chk(rv, (c >= 1 && c <= 24) ? 8'h10 : 8'h00);
    end
    // Empty round first: copy must restart counts, not keep them
    for (int k = 0; k < 3; k++) begin
      events(k * 40);
      wr(tpc_pkg::ADDR_PERF_MONITOR_CTRL, 8'h00);
      wr(tpc_pkg::ADDR_PERF_MONITOR_CTRL, 8'h02);
      for (int i = 0; i < 7; i++) begin
        snap[i] = cnt[i];
        cnt[i] = 16'h0;
      end
      chkSnap();
    end
    for (int n = 0; n < 60; n++) begin
      ch = 1 + $urandom % 24;
      if ($urandom % 6 == 0) begin
        en[ch] = ~en[ch];
        iwr(ch, {3'h0, en[ch], 4'h0});
      end
      sixteen = 1'($urandom);
      wr(tpc_pkg::ADDR_SIG_CFG, {7'h0, sixteen});
      @(negedge clk);
      lineFormat = tpc_pkg::tpc_fmt_t'($urandom % 4);
      frameSynced = ($urandom % 5) != 0;
      sigChannel = 5'(ch);
      sigBits = 4'($urandom);
      sigStrobe = 1'b1;
      @(negedge clk);
      sigStrobe = 1'b0;
      hit = frameSynced && lineFormat != tpc_pkg::FMT_DM && en[ch];
      fl = 8'(hit && shape(lineFormat, sixteen, sigBits) != sig[ch]) << ((ch - 1) % 8);
      if (hit) begin
        sig[ch] = shape(lineFormat, sixteen, sigBits);
      end
      ird(ch, rv);
      chk(rv, {3'h0, en[ch], sig[ch]});
      grp = tpc_pkg::ADDR_CHG0 + 8'((ch - 1) / 8);
      rd(grp, rv);
      chk(rv, fl);
      wr(grp, 8'hff);
    end
    // Steady events: every full auto interval holds exactly SEC of them
    crcRun = 1'b1;
    wr(tpc_pkg::ADDR_PERF_MONITOR_CTRL, 8'h01);
    repeat (3 * SEC) @(negedge clk);
    wr(tpc_pkg::ADDR_PERF_MONITOR_CTRL, 8'h00);
    crcRun = 1'b0;
    wr(tpc_pkg::ADDR_PERF_MONITOR_SEL, tpc_pkg::PM_CRC_LO);
    rd(tpc_pkg::ADDR_PERF_MONITOR_DATA, rv);
    chk(rv, 8'(SEC));
    results();
  end
endmodule
`default_nettype wire
